// file: vdc_regs.sv
// Decoder control register bank with decoded mode outputs and the contrast stage.
`timescale 1ns/1ps
module vdc_regs
    import vdc_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       reset,
    // Register access port from the serial control bus front end.
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    // Decoder controls.
    output logic      [1:0] separation_mode,
    output logic            reference_code_disable,
    output logic            ref_code_insert,
    output logic      [1:0] interpolator_mode,
    output logic            interp_active,
    output logic      [1:0] clock_lock_mode,
    output logic      [7:0] luma_gain_value,
    output logic      [7:0] chroma_gain_value,
    output logic            luma_gain_unity,
    output logic            chroma_gain_unity,
    output logic            agc_enable,
    output logic      [1:0] gain_dead_band,
    output logic      [2:0] dead_band_lsb,
    output logic            sharpen_enable,
    output logic            auto_colour_enable,
    output logic            contrast_pivot_select,
    output logic            colour_kill_disable,
    output logic            colour_kill_enable,
    output logic      [6:0] contrast_factor,
    // Luma datapath through the contrast stage.
    input  wire logic [7:0] luma_in,
    output logic      [7:0] luma_out
);
    // Stored registers, all bits writable including reserved ones.
    logic [7:0] ctrl_one_r;      // Separation, code insert, interpolator, clock mode.
    logic [7:0] spare_r;         // Reserved register kept at its written value.
    logic [7:0] luma_gain_r;     // Composite and luma path gain code.
    logic [7:0] chroma_gain_r;   // Chroma path gain code.
    logic [7:0] gain_col_r;      // Gain and colour control bits.
    logic [7:0] contrast_r;      // Contrast factor plus reserved bit 7.

    // Write strobe decode, shared by every register.
    function automatic logic wr_hit(input logic [7:0] a, input logic w, input logic [7:0] target);
        wr_hit = w && (a == target);
    endfunction

    // Unity gain test: code 0x3C gives (150 + 251.5) / 401.5 = 1, so 0 dB.
    function automatic logic is_unity(input logic [7:0] g);
        is_unity = (g == VDC_RST_GAIN);
    endfunction

    // First control register; reset clears all bits, reserved bit 3 stays writable.
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_one_r <= VDC_RST_CTRL_ONE;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_CTRL_ONE)) begin
            ctrl_one_r <= reg_wdata;
        end
    end

    // Reserved register; storing it lets the host read back what it wrote.
    always_ff @(posedge mclk) begin
        if (reset) begin
            spare_r <= VDC_RST_SPARE;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_SPARE)) begin
            spare_r <= reg_wdata;
        end
    end

    // Composite and luma gain register.
    always_ff @(posedge mclk) begin
        if (reset) begin
            luma_gain_r <= VDC_RST_GAIN;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_LUMA_GAIN)) begin
            luma_gain_r <= reg_wdata;
        end
    end

    // Chroma gain register.
    always_ff @(posedge mclk) begin
        if (reset) begin
            chroma_gain_r <= VDC_RST_GAIN;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_CHRO_GAIN)) begin
            chroma_gain_r <= reg_wdata;
        end
    end

    // Gain and colour control register.
    always_ff @(posedge mclk) begin
        if (reset) begin
            gain_col_r <= VDC_RST_GAIN_COL;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_GAIN_COL)) begin
            gain_col_r <= reg_wdata;
        end
    end

    // Contrast register; bit 7 is reserved but stored so readback matches the write.
    always_ff @(posedge mclk) begin
        if (reset) begin
            contrast_r <= VDC_RST_CONTRAST;
        end else if (wr_hit(reg_addr, reg_wr, VDC_ADDR_CONTRAST)) begin
            contrast_r <= reg_wdata;
        end
    end

    // Read mux; unmapped addresses read zero and drop reg_hit so the front end can refuse them.
    always_comb begin
        reg_hit = 1'b1;
        case (reg_addr)
            VDC_ADDR_CTRL_ONE:  reg_rdata = ctrl_one_r;
            VDC_ADDR_SPARE:     reg_rdata = spare_r;
            VDC_ADDR_LUMA_GAIN: reg_rdata = luma_gain_r;
            VDC_ADDR_CHRO_GAIN: reg_rdata = chroma_gain_r;
            VDC_ADDR_GAIN_COL:  reg_rdata = gain_col_r;
            VDC_ADDR_CONTRAST:  reg_rdata = contrast_r;
            default: begin
                reg_rdata = 8'h00;
                reg_hit   = 1'b0;
            end
        endcase
    end

    // Raw field views of the first control register.
    assign separation_mode        = ctrl_one_r[VDC_SEP_LSB +: 2];
    assign reference_code_disable = ctrl_one_r[VDC_REFDIS];
    assign ref_code_insert        = ~ctrl_one_r[VDC_REFDIS];
    assign interpolator_mode      = ctrl_one_r[VDC_INTP_LSB +: 2];
    assign clock_lock_mode        = ctrl_one_r[VDC_CLK_LSB +: 2];

    // Interpolator state: forced on runs, auto follows the clock mode (runs unless line-locked).
    // Reserved code is treated as off so a bad write cannot start an unexpected mode.
    always_comb begin
        case (vdc_intp_type'(interpolator_mode))
            VDC_INT_AUTO: interp_active = (vdc_clk_type'(clock_lock_mode) != VDC_CLK_LINE);
            VDC_INT_ON:   interp_active = 1'b1;
            VDC_INT_OFF:  interp_active = 1'b0;
            default:      interp_active = 1'b0;
        endcase
    end

    // Gain codes go straight to the input amplifiers, whose law is logarithmic in the code.
    assign luma_gain_value    = luma_gain_r;
    assign chroma_gain_value  = chroma_gain_r;
    assign luma_gain_unity    = is_unity(luma_gain_r);
    assign chroma_gain_unity  = is_unity(chroma_gain_r);

    // Gain and colour field views.
    assign agc_enable            = gain_col_r[VDC_AGC_EN];
    assign gain_dead_band        = gain_col_r[VDC_CORE_LSB +: 2];
    assign sharpen_enable        = gain_col_r[VDC_SHARPEN_ENABLE];
    assign auto_colour_enable    = gain_col_r[VDC_AUTO_COL];
    assign contrast_pivot_select = gain_col_r[VDC_PIVOT];
    assign colour_kill_disable   = gain_col_r[VDC_KILLDIS];
    assign colour_kill_enable    = ~gain_col_r[VDC_KILLDIS];
    assign contrast_factor       = contrast_r[6:0];

    // Dead band width in LSB; code 3 gives zero width, no dead band at all.
    always_comb begin
        case (gain_dead_band)
            2'b00:   dead_band_lsb = 3'h2;
            2'b01:   dead_band_lsb = 3'h3;
            2'b10:   dead_band_lsb = 3'h4;
            default: dead_band_lsb = 3'h0;
        endcase
    end

    // Contrast stage; new settings apply to the next sample after the write.
    vdc_contrast u_contrast (
        .mclk                  (mclk),
        .reset                 (reset),
        .contrast_factor       (contrast_factor),
        .contrast_pivot_select (contrast_pivot_select),
        .luma_in               (luma_in),
        .luma_out              (luma_out)
    );
endmodule

// file: vdc_pkg.sv
// Package with register map, field layout, reset values and mode encodings of the decoder control bank.
// Contract
// - Two-bit field selects luma/chroma separation method.
// - Bit 2 set suppresses EAV/SAV timing codes.
// - Two-bit field selects pixel interpolator mode.
// - Two-bit field selects clock locking mode.
// - First control register resets zero, bit3 reserved.
// - Register 0x09 reserved, resets to zero.
// - First gain drives composite and luma paths.
// - Second gain drives chroma input path.
// - Gain law is logarithmic in the code.
// - Gain code 0x3C gives unity gain.
// - Bit 0 enables automatic gain control.
// - Coring field sets gain control dead band.
// - Bit 4 enables sharpness filtering.
// - Bit 5 enables automatic colour control.
// - Pivot select: 0 gives 50%, 1 gives 0%.
// - Bit 7 set disables the colour killer.
// - Contrast gain seven bits, resets to 0x40.
// - Output luma follows contrast equation per pivot.
package vdc_pkg;
    // Sub-addresses of the bank.
    localparam logic [7:0] VDC_ADDR_CTRL_ONE  = 8'h08;
    localparam logic [7:0] VDC_ADDR_SPARE     = 8'h09;
    localparam logic [7:0] VDC_ADDR_LUMA_GAIN = 8'h0A;
    localparam logic [7:0] VDC_ADDR_CHRO_GAIN = 8'h0B;
    localparam logic [7:0] VDC_ADDR_GAIN_COL  = 8'h0C;
    localparam logic [7:0] VDC_ADDR_CONTRAST  = 8'h0D;
    // Reset values.
    localparam logic [7:0] VDC_RST_CTRL_ONE   = 8'h00;
    localparam logic [7:0] VDC_RST_SPARE      = 8'h00;
    localparam logic [7:0] VDC_RST_GAIN       = 8'h3C;
    localparam logic [7:0] VDC_RST_GAIN_COL   = 8'h00;
    localparam logic [7:0] VDC_RST_CONTRAST   = 8'h40;
    // Field positions in the first control register.
    localparam int VDC_SEP_LSB   = 0;
    localparam int VDC_REFDIS    = 2;
    localparam int VDC_INTP_LSB  = 4;
    localparam int VDC_CLK_LSB   = 6;
    // Field positions in the gain and colour register.
    localparam int VDC_AGC_EN    = 0;
    localparam int VDC_CORE_LSB  = 2;
    localparam int VDC_SHARPEN_ENABLE     = 4;
    localparam int VDC_AUTO_COL  = 5;
    localparam int VDC_PIVOT     = 6;
    localparam int VDC_KILLDIS   = 7;
    // Contrast arithmetic constants.
    localparam logic [7:0] VDC_LUMA_MID       = 8'h80;
    localparam int         VDC_CONTRAST_SHIFT = 6;
    // Separation method codes.
    typedef enum logic [1:0] {
        VDC_SEP_ADAPT = 2'b00, VDC_SEP_1D = 2'b01, VDC_SEP_2D = 2'b10, VDC_SEP_RSVD = 2'b11
    } vdc_sep_type;
    // Interpolator codes.
    typedef enum logic [1:0] {
        VDC_INT_AUTO = 2'b00, VDC_INT_ON = 2'b01, VDC_INT_OFF = 2'b10, VDC_INT_RSVD = 2'b11
    } vdc_intp_type;
    // Clock mode codes.
    typedef enum logic [1:0] {
        VDC_CLK_AUTO = 2'b00, VDC_CLK_LINE = 2'b01, VDC_CLK_FRAME = 2'b10, VDC_CLK_FIXED = 2'b11
    } vdc_clk_type;
endpackage

// file: vdc_contrast.sv
// Contrast stage that scales luma by a seven-bit factor around a selectable pivot.
`timescale 1ns/1ps
module vdc_contrast
    import vdc_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       reset,
    // Settings.
    input  wire logic [6:0] contrast_factor,
    input  wire logic       contrast_pivot_select,
    // Luma in and out.
    input  wire logic [7:0] luma_in,
    output logic      [7:0] luma_out
);
    // Signed product, wide enough for 255 * 127 with sign.
    logic signed [17:0] centred;     // Input less the pivot.
    logic signed [17:0] scaled;      // Product shifted by the factor scale.
    logic signed [17:0] result;      // Value before clamping.

    // Pivot 0 centres at mid-scale, pivot 1 scales from black.
    always_comb begin
        if (contrast_pivot_select) begin
            centred = $signed({10'h000, luma_in});
        end else begin
            centred = $signed({10'h000, luma_in}) - $signed({10'h000, VDC_LUMA_MID});
        end
        scaled = (centred * $signed({11'h000, contrast_factor})) >>> VDC_CONTRAST_SHIFT;
        result = contrast_pivot_select ? scaled : scaled + $signed({10'h000, VDC_LUMA_MID});
    end

    // Registered output, clamped to the eight-bit range so gains above one cannot wrap.
    always_ff @(posedge mclk) begin
        if (reset) begin
            luma_out <= 8'h00;
        end else if (result < 0) begin
            luma_out <= 8'h00;
        end else if (result > 18'sh000FF) begin
            luma_out <= 8'hFF;
        end else begin
            luma_out <= result[7:0];
        end
    end
endmodule

// file: vdc_regs_sva.sv
// Checker for the ports of the decoder control register bank.
`timescale 1ns/1ps
module vdc_regs_sva
    import vdc_pkg::*;
(
    // Clock, reset and write port.
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    // Decoded controls and luma.
    input wire logic [1:0] separation_mode,
    input wire logic       ref_code_insert,
    input wire logic [1:0] interpolator_mode,
    input wire logic [1:0] clock_lock_mode,
    input wire logic [7:0] luma_gain_value,
    input wire logic       luma_gain_unity,
    input wire logic [7:0] chroma_gain_value,
    input wire logic       agc_enable,
    input wire logic       colour_kill_enable,
    input wire logic [1:0] gain_dead_band,
    input wire logic [2:0] dead_band_lsb,
    input wire logic [6:0] contrast_factor,
    input wire logic [7:0] luma_in,
    input wire logic [7:0] luma_out
);
    // One clock; reset reloads every register, so the checks rest meanwhile.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    mode_fields_a: assert property (reg_wr && reg_addr == VDC_ADDR_CTRL_ONE |=>
        {clock_lock_mode, interpolator_mode, ~ref_code_insert, separation_mode} ==
        {$past(reg_wdata[7:4]), $past(reg_wdata[2:0])}) else $error("mode fields wrong");
    gain_write_a: assert property (reg_wr && reg_addr == VDC_ADDR_LUMA_GAIN |=>
        luma_gain_value == $past(reg_wdata) && luma_gain_unity == ($past(reg_wdata) == 8'h3C))
        else $error("luma gain wrong");
    colour_bits_a: assert property (reg_wr && reg_addr == VDC_ADDR_GAIN_COL |=>
        agc_enable == $past(reg_wdata[0]) && colour_kill_enable == !$past(reg_wdata[7])) else $error("colour bits wrong");
    dead_band_a: assert property (dead_band_lsb == ((gain_dead_band == 2'h3) ? 3'h0 : 3'h2 + gain_dead_band))
        else $error("dead band wrong");
    contrast_write_a: assert property (reg_wr && reg_addr == VDC_ADDR_CONTRAST |=>
        contrast_factor == $past(reg_wdata[6:0])) else $error("contrast factor wrong");
    // Without a write the settings must not drift.
    settings_hold_a: assert property (!reg_wr |=> $stable(contrast_factor) && $stable(luma_gain_value))
        else $error("setting changed without write");
    reset_values_a: assert property ($past(reset) |-> luma_gain_value == 8'h3C && chroma_gain_value == 8'h3C &&
        contrast_factor == 7'h40 && clock_lock_mode == 2'h0) else $error("reset value wrong");
    // Factor 64 is unity at either pivot, so luma passes through with one cycle of delay.
    luma_unity_a: assert property (contrast_factor == 7'h40 |=> luma_out == $past(luma_in))
        else $error("luma not passed at unity");
    cover property (reg_wr && reg_addr == VDC_ADDR_CONTRAST);
    cover property (reg_wr && reg_addr == VDC_ADDR_CTRL_ONE && reg_wdata[7:6] == 2'h3);
    cover property (gain_dead_band == 2'h3 && agc_enable);
endmodule

// file: vdc_host_model.sv
// Host model that writes and reads the bank through its access port.
`timescale 1ns/1ps
module vdc_host_model (
    // Clock and read data in, access port out.
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    // Idle bus from time zero.
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    // One write; data is inverted afterwards so a stale byte cannot pass as valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    // Read data is combinational and taken at the next rising edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        @(posedge mclk);
        d = reg_rdata;
    endtask
endmodule

// file: tb_video_decoder_control_regs.sv
// Self-checking bench for the decoder control register bank.
`timescale 1ns/1ps
module tb_video_decoder_control_regs;
    import vdc_pkg::*;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] luma_in = 8'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic       reg_wr, reg_hit;
    int         n_errors = 0;
    int         checks = 0;
    always #12.5 mclk = ~mclk;
    vdc_host_model host_u (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));
    vdc_regs dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_hit(reg_hit), .separation_mode(), .reference_code_disable(),
        .ref_code_insert(), .interpolator_mode(), .interp_active(), .clock_lock_mode(), .luma_gain_value(),
        .chroma_gain_value(), .luma_gain_unity(), .chroma_gain_unity(), .agc_enable(), .gain_dead_band(),
        .dead_band_lsb(), .sharpen_enable(), .auto_colour_enable(), .contrast_pivot_select(),
        .colour_kill_disable(), .colour_kill_enable(), .contrast_factor(), .luma_in(luma_in), .luma_out());
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        checks++;
        if (got !== ex) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // All six registers read their reset contents; an unmapped address reads zero, no hit.
    task automatic t_defaults;
        logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h3C, 8'h3C, 8'h00, 8'h40};
        for (int i = 0; i < 6; i++) begin
            host_u.rd(8'h08 + 8'(i), rv);
            chk("reset value", ex[i], rv);
            chk("register hit", 8'h01, 8'(reg_hit));
        end
        host_u.rd(8'h0E, rv);
        chk("unmapped read", 8'h00, rv | 8'(reg_hit));
    endtask
    // Every code of each mode field, with the reserved bit set alongside.
    task automatic t_control;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            host_u.wr(VDC_ADDR_CTRL_ONE, {c, c, 1'b1, c[0], c});
            chk("separation", 8'(c), 8'(dut_u.separation_mode));
            chk("clock mode", 8'(c), 8'(dut_u.clock_lock_mode));
            chk("code insert", {7'h00, ~c[0]}, 8'(dut_u.ref_code_insert));
            chk("code disable", {7'h00, c[0]}, 8'(dut_u.reference_code_disable));
            chk("interpolator", 8'({c, c < 2'h2}), 8'({dut_u.interpolator_mode, dut_u.interp_active}));
            host_u.rd(VDC_ADDR_CTRL_ONE, rv);
            chk("control readback", {c, c, 1'b1, c[0], c}, rv);
        end
        // Automatic interpolation is off while the clock is line-locked.
        host_u.wr(VDC_ADDR_CTRL_ONE, 8'h40);
        chk("auto interp line", 8'h00, 8'(dut_u.interp_active));
    endtask
    // Only the code 0x3C may flag unity gain.
    task automatic t_gain;
        host_u.wr(VDC_ADDR_LUMA_GAIN, 8'h3D);
        host_u.wr(VDC_ADDR_CHRO_GAIN, 8'h3C);
        chk("luma gain", 8'h3D, dut_u.luma_gain_value);
        chk("chroma gain", 8'h3C, dut_u.chroma_gain_value);
        chk("unity flags", 8'h01, 8'({dut_u.luma_gain_unity, dut_u.chroma_gain_unity}));
    endtask
    // Each dead band code with the single-bit enables toggled alongside.
    task automatic t_colour;
        logic [1:0] c;
        logic [2:0] band [4] = '{3'h2, 3'h3, 3'h4, 3'h0};
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            host_u.wr(VDC_ADDR_GAIN_COL, {c[0], 1'b0, c[1], c[0], c, 1'b1, c[1]});
            chk("dead band", 8'(band[i]), 8'(dut_u.dead_band_lsb));
            chk("dead band code", 8'(c), 8'(dut_u.gain_dead_band));
            chk("kill disable", {7'h00, c[0]}, 8'(dut_u.colour_kill_disable));
            chk("colour bits", 8'({c[1], c[0], c[1], 1'b0, ~c[0]}), 8'({dut_u.agc_enable, dut_u.sharpen_enable,
                dut_u.auto_colour_enable, dut_u.contrast_pivot_select, dut_u.colour_kill_enable}));
        end
    endtask
    // Luma at both pivots, both clamps; the last byte leaves the reserved bit set.
    task automatic t_contrast;
        logic [7:0] v [5][4] = '{'{8'h00, 8'hA0, 8'd200, 8'd164}, '{8'h00, 8'hA0, 8'd0, 8'd64},
            '{8'h40, 8'hA0, 8'd200, 8'd100}, '{8'h40, 8'hFF, 8'd255, 8'd255}, '{8'h00, 8'hFF, 8'd0, 8'd0}};
        for (int i = 0; i < 5; i++) begin
            host_u.wr(VDC_ADDR_GAIN_COL, v[i][0]);
            host_u.wr(VDC_ADDR_CONTRAST, v[i][1]);
            luma_in = v[i][2];
            @(negedge mclk);
            chk("luma out", v[i][3], dut_u.luma_out);
        end
        host_u.rd(VDC_ADDR_CONTRAST, rv);
        chk("contrast readback", 8'hFF, rv);
        chk("contrast factor", 8'h7F, 8'(dut_u.contrast_factor));
    endtask
    // A mid-run reset must bring every default back.
    initial begin
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        t_defaults;
        t_control;
        t_gain;
        t_colour;
        t_contrast;
        @(negedge mclk);
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        t_defaults;
        complete_run;
    end
    // The run needs about ninety cycles; 5000 leaves ample headroom.
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        complete_run;
    end
endmodule
bind vdc_regs vdc_regs_sva chk_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .separation_mode(separation_mode), .ref_code_insert(ref_code_insert),
    .interpolator_mode(interpolator_mode), .clock_lock_mode(clock_lock_mode), .luma_gain_value(luma_gain_value),
    .luma_gain_unity(luma_gain_unity), .chroma_gain_value(chroma_gain_value), .agc_enable(agc_enable),
    .colour_kill_enable(colour_kill_enable), .gain_dead_band(gain_dead_band), .dead_band_lsb(dead_band_lsb),
    .contrast_factor(contrast_factor), .luma_in(luma_in), .luma_out(luma_out));
